// ===== hdl/wwd_pkg.sv
// Constants, register map and carrier types of the windowed watchdog.
// Assumes an APB master with 32-bit data and a byte address of 8 bits.
package wwd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0    = 8'h00;
  localparam logic [7:0] ADDR_CTRL1    = 8'h04;
  localparam logic [7:0] ADDR_PSC_LOW  = 8'h08;
  localparam logic [7:0] ADDR_PSC_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_WIN_CNT  = 8'h10;
  localparam logic [7:0] ADDR_CAUSE    = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_EN_BIT   = 0;
  localparam int CTRL0_PS_LSB   = 1;
  localparam int CTRL1_WIN_LSB  = 0;
  localparam int CTRL1_CS_LSB   = 4;
  localparam int TMR_PSC_LSB    = 0;
  localparam int TMR_STATE_BIT  = 2;
  localparam int TMR_WIN_LSB    = 3;
  localparam int CAUSE_RWD_BIT  = 4;
  localparam int CAUSE_WV_BIT   = 5;
  localparam int STAT_PD_BIT    = 3;
  localparam int STAT_TO_BIT    = 4;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [4:0] PERIOD_DEFAULT = 5'h0b;
  localparam logic [4:0] PERIOD_SW_SEL  = 5'h1f;
  localparam logic [4:0] PERIOD_MAX     = 5'h12;
  localparam logic [4:0] PERIOD_MIN     = 5'h00;
  localparam logic [2:0] WINDOW_SW_SEL  = 3'h7;
  localparam logic [2:0] WINDOW_FULL    = 3'h7;
  localparam logic [2:0] WINDOW_DEFAULT = 3'h7;
  localparam logic [2:0] CLOCK_SW_SEL   = 3'h7;
  localparam logic [2:0] CLOCK_DEFAULT  = 3'h0;
  localparam logic [1:0] MODE_ALWAYS    = 2'h3;
  localparam logic [1:0] MODE_AWAKE     = 2'h2;
  localparam logic [1:0] MODE_SOFT      = 2'h1;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int CNT_W   = 23;
  localparam int PSC_W   = 18;
  localparam int WIN_W   = 5;
  localparam int PS_BASE = 5;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } wwd_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wwd_apb_rsp_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [4:0] periodSel;
    logic [2:0] windowSel;
    logic [2:0] clockSel;
  } wwd_cfg_s;

  typedef struct packed {
    logic sleeping;
    logic clearInstr;
    logic ostRunning;
  } wwd_core_s;

endpackage

// ===== hdl/wwd_pin_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/100ps
module wwd_pin_sync (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ----------------------------------------------------------------
  // Level accepted once the second and third stages agree
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

  assign rise = (stage2 == stage3) & stage3 & ~level;

endmodule

// ===== hdl/wwd_window_check.sv
// Window-open decision from the five top bits of the watchdog count.
// Assumes the window code is already resolved between fuse and software.
`timescale 1ns/100ps
module wwd_window_check (
  input  wire logic [2:0] windowCode,
  input  wire logic [4:0] windowValue,
  output logic            windowOpen
);

  import wwd_pkg::*;

  // Closed below (7 - code) * 4, open to the end of the period
  wire logic [4:0] threshold = {~windowCode, 2'b00};

  assign windowOpen = (windowCode == WINDOW_FULL) |
                      (windowValue >= threshold);

endmodule

// ===== hdl/wwd_windowed_watchdog.sv
// Windowed watchdog: period counter, window check, arming, resets, wake.
// Assumes the slow watchdog oscillator arrives as an asynchronous pin and
// the core delivers sleep, clear and start-up state on core_clk.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module wwd_windowed_watchdog (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire wwd_pkg::wwd_apb_req_s apbReq,
  output wwd_pkg::wwd_apb_rsp_s      apbRsp,
  input  wire wwd_pkg::wwd_cfg_s     cfg,
  input  wire wwd_pkg::wwd_core_s    core,
  input  wire logic                  wdogOscPin,
  output logic                       resetRequest,
  output logic                       wakeRequest
);

  import wwd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0]       swPeriodSelect;
  logic             softEnable;
  logic [2:0]       swWindowSelect;
  logic [2:0]       swClockSelect;
  logic [CNT_W-1:0] count;
  logic             armed;
  logic             sleepSeen;
  logic             timeoutStatus;
  logic             powerdownStatus;
  logic             windowViolation_n;
  logic             watchdogReset_n;

  // ----------------------------------------------------------------
  // Watchdog oscillator tick
  // ----------------------------------------------------------------
  logic oscTick;

  wwd_pin_sync u_osc_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pinIn    (wdogOscPin),
    .level    (),
    .rise     (oscTick)
  );

  // ----------------------------------------------------------------
  // Period and window selection
  // ----------------------------------------------------------------
  wire logic       periodBySw = (cfg.periodSel == PERIOD_SW_SEL);
  wire logic       windowBySw = (cfg.windowSel == WINDOW_SW_SEL);
  wire logic       clockBySw  = (cfg.clockSel == CLOCK_SW_SEL);

  wire logic [4:0] periodCode = periodBySw ? swPeriodSelect
                                           : cfg.periodSel;
  wire logic [4:0] periodUsed = (periodCode > PERIOD_MAX) ? PERIOD_MIN
                                                          : periodCode;
  wire logic [2:0] windowCode = windowBySw ? swWindowSelect
                                           : cfg.windowSel;
  wire logic [2:0] clockCode  = clockBySw ? swClockSelect : cfg.clockSel;
  wire logic       windowMode = (windowCode != WINDOW_FULL);

  // Divide ratio 2^(5+code); the count ends one below it
  wire logic [CNT_W:0]   periodSpan = (CNT_W+1)'(1) << (PS_BASE + int'(periodUsed));
  wire logic [CNT_W-1:0] lastCount  = CNT_W'(periodSpan - (CNT_W+1)'(1));
  wire logic [CNT_W-1:0] lowMask    = CNT_W'((CNT_W+1)'(1) << periodUsed)
                                      - CNT_W'(1);

  // Five top bits of the running period, and the prescale part below them
  wire logic [WIN_W-1:0] windowValue = WIN_W'(count >> periodUsed);
  wire logic [PSC_W-1:0] prescaleCnt = PSC_W'(count & lowMask);

  logic windowOpen;

  wwd_window_check u_window (
    .windowCode  (windowCode),
    .windowValue (windowValue),
    .windowOpen  (windowOpen)
  );

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  wire logic modeAlways = (cfg.mode == MODE_ALWAYS);
  wire logic modeAwake  = (cfg.mode == MODE_AWAKE);
  wire logic modeSoft   = (cfg.mode == MODE_SOFT);
  wire logic enabled    = modeAlways |
                          (modeAwake & ~core.sleeping) |
                          (modeSoft & softEnable);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic accessPhase = apbReq.psel & apbReq.penable;
  wire logic accessDone  = accessPhase & apbRsp.pready;
  wire logic busWrite    = accessDone & apbReq.pwrite;
  wire logic busRead     = accessDone & ~apbReq.pwrite;

  wire logic hitCtrl0    = (apbReq.paddr == ADDR_CTRL0);
  wire logic hitCtrl1    = (apbReq.paddr == ADDR_CTRL1);
  wire logic hitPscLow   = (apbReq.paddr == ADDR_PSC_LOW);
  wire logic hitPscHigh  = (apbReq.paddr == ADDR_PSC_HIGH);
  wire logic hitWinCnt   = (apbReq.paddr == ADDR_WIN_CNT);
  wire logic hitCause    = (apbReq.paddr == ADDR_CAUSE);
  wire logic hitStatus   = (apbReq.paddr == ADDR_STATUS);
  wire logic hitAny      = hitCtrl0 | hitCtrl1 | hitPscLow | hitPscHigh |
                           hitWinCnt | hitCause | hitStatus;

  wire logic wrCtrl0     = busWrite & hitCtrl0;
  wire logic wrCtrl1     = busWrite & hitCtrl1;
  wire logic wrCause     = busWrite & hitCause;
  wire logic rdCtrl0     = busRead & hitCtrl0;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [7:0] ctrl0Word = {2'b00, periodCode, softEnable};
  wire logic [7:0] ctrl1Word = {1'b0, clockCode, 1'b0, windowCode};
  wire logic [7:0] winWord   = {windowValue, armed,
                                prescaleCnt[PSC_W-1:16]};
  wire logic [7:0] causeWord = {2'b00, windowViolation_n, watchdogReset_n,
                                4'h0};
  wire logic [7:0] statWord  = {3'b000, timeoutStatus, powerdownStatus,
                                3'b000};

  wire logic [7:0] readByte =
    hitCtrl0   ? ctrl0Word :
    hitCtrl1   ? ctrl1Word :
    hitPscLow  ? prescaleCnt[7:0] :
    hitPscHigh ? prescaleCnt[15:8] :
    hitWinCnt  ? winWord :
    hitCause   ? causeWord :
    hitStatus  ? statWord : 8'h00;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  wire logic sleepEnter  = core.sleeping & ~sleepSeen;
  wire logic sleepExit   = ~core.sleeping & sleepSeen;
  wire logic clearGood   = armed & windowOpen;
  wire logic clearValid  = enabled & core.clearInstr &
                           (~windowMode | clearGood);
  wire logic violation   = enabled & core.clearInstr & windowMode &
                           ~clearGood;
  // A count held clear by the start-up timer cannot reach its end
  wire logic timeout     = enabled & oscTick & ~core.ostRunning &
                           (count == lastCount);
  wire logic sleepTimeout = timeout & core.sleeping;
  wire logic awakeTimeout = timeout & ~core.sleeping;

  // Divider setting writes to CTRL0 and CTRL1 are a clearing source, so they clear the count
  wire logic clearCount  = clearValid | violation | timeout |
                           sleepEnter | sleepExit |
                           ~enabled |
                           core.ostRunning |
                           wrCtrl0 | wrCtrl1;

  // ----------------------------------------------------------------
  // APB slave: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= accessPhase & ~apbRsp.pready;
      apbRsp.pslverr <= accessPhase & ~apbRsp.pready & ~hitAny;
      apbRsp.prdata  <= (accessPhase & ~apbRsp.pready & ~apbReq.pwrite) ?
                        {24'h000000, readByte} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      swPeriodSelect <= PERIOD_DEFAULT;
      softEnable     <= 1'b0;
      swWindowSelect <= WINDOW_DEFAULT;
      swClockSelect  <= CLOCK_DEFAULT;
    end else begin
      if (wrCtrl0) begin
        softEnable <= apbReq.pwdata[CTRL0_EN_BIT];
        if (periodBySw) begin
          swPeriodSelect <= apbReq.pwdata[CTRL0_PS_LSB +: 5];
        end
      end
      if (wrCtrl1) begin
        if (windowBySw) begin
          swWindowSelect <= apbReq.pwdata[CTRL1_WIN_LSB +: 3];
        end
        if (clockBySw) begin
          swClockSelect <= apbReq.pwdata[CTRL1_CS_LSB +: 3];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and arming
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count     <= '0;
      armed     <= 1'b0;
      sleepSeen <= 1'b0;
    end else begin
      sleepSeen <= core.sleeping;
      if (clearCount) begin
        count <= '0;
      end else if (oscTick) begin
        count <= count + CNT_W'(1);
      end
      // An arming read in the same cycle as a clearing event wins
      if (rdCtrl0) begin
        armed <= 1'b1;
      end else if (clearCount) begin
        armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset cause, core status, reset and wake requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      windowViolation_n <= 1'b1;
      watchdogReset_n   <= 1'b1;
      timeoutStatus     <= 1'b1;
      powerdownStatus   <= 1'b1;
      resetRequest      <= 1'b0;
      wakeRequest       <= 1'b0;
    end else begin
      resetRequest <= awakeTimeout | violation;
      wakeRequest  <= sleepTimeout;
      // Hardware clearing wins over a firmware write
      if (violation) begin
        windowViolation_n <= 1'b0;
      end else if (wrCause) begin
        windowViolation_n <= apbReq.pwdata[CAUSE_WV_BIT];
      end
      if (timeout) begin
        watchdogReset_n <= 1'b0;
      end else if (wrCause) begin
        watchdogReset_n <= apbReq.pwdata[CAUSE_RWD_BIT];
      end
      if (sleepTimeout) begin
        timeoutStatus   <= 1'b0;
        powerdownStatus <= 1'b0;
      end else if (awakeTimeout) begin
        timeoutStatus <= 1'b0;
      end else if (clearValid) begin
        timeoutStatus   <= 1'b1;
        powerdownStatus <= 1'b1;
      end else if (sleepEnter) begin
        timeoutStatus   <= 1'b1;
        powerdownStatus <= 1'b0;
      end
    end
  end

endmodule

// ===== tb/wwd_asserts.sv
// Concurrent checks on the ports of the windowed watchdog.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/100ps
module wwd_asserts
  import wwd_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  resetn,
  input wire wwd_pkg::wwd_apb_req_s apbReq,
  input wire wwd_pkg::wwd_apb_rsp_s apbRsp,
  input wire wwd_pkg::wwd_cfg_s     cfg,
  input wire wwd_pkg::wwd_core_s    core,
  input wire logic                  wdogOscPin,
  input wire logic                  resetRequest,
  input wire logic                  wakeRequest
);
  // ----------------------------------------------------------------
  // Armed shadow, seen from the bus
  // ----------------------------------------------------------------
  logic armedH;
  logic prevSleep;
  wire  done  = apbReq.psel & apbReq.penable & apbRsp.pready;
  wire  armRd = done & ~apbReq.pwrite & (apbReq.paddr == ADDR_CTRL0);
  wire  ctlWr = done & apbReq.pwrite & (apbReq.paddr == ADDR_CTRL0 | apbReq.paddr == ADDR_CTRL1);
  wire  drop  = core.clearInstr | resetRequest | wakeRequest | ctlWr | core.ostRunning |
                (core.sleeping ^ prevSleep);
  wire  winOn = (cfg.windowSel != WINDOW_SW_SEL) & (cfg.mode == MODE_ALWAYS) & ~core.sleeping;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      armedH    <= 1'b0;
      prevSleep <= 1'b0;
    end else begin
      armedH    <= armRd | (armedH & ~drop);
      prevSleep <= core.sleeping;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_apb_wait;
    apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("access phase left unanswered");
  property p_rd_zero;
    !apbRsp.pready |-> apbRsp.prdata == 32'h0 && !apbRsp.pslverr;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data or error outside pready");
  property p_rst_pulse;
    resetRequest |=> !resetRequest;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request longer than a cycle");
  property p_wake_sleep;
    wakeRequest |-> $past(core.sleeping) && !resetRequest;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake without sleep");
  property p_sleep_noreset;
    core.sleeping && $past(core.sleeping) |-> !resetRequest;
  endproperty
  a_sleep_noreset: assert property (p_sleep_noreset) else $error("reset during sleep");
  property p_ost;
    core.ostRunning |=> !resetRequest && !wakeRequest;
  endproperty
  a_ost: assert property (p_ost) else $error("time-out while start-up timer runs");
  property p_off;
    cfg.mode == 2'h0 |=> !resetRequest && !wakeRequest;
  endproperty
  a_off: assert property (p_off) else $error("request while watchdog is off");
  property p_unarmed;
    core.clearInstr && !armedH && winOn && !core.ostRunning |=> resetRequest;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed clear not refused");
  property p_clr_quiet;
    core.clearInstr ##1 !core.clearInstr |=> !resetRequest && !wakeRequest;
  endproperty
  a_clr_quiet: assert property (p_clr_quiet) else $error("request right after a clear");
endmodule

bind wwd_windowed_watchdog wwd_asserts i_chk (.core_clk(core_clk), .resetn(resetn),
  .apbReq(apbReq), .apbRsp(apbRsp), .cfg(cfg), .core(core), .wdogOscPin(wdogOscPin),
  .resetRequest(resetRequest), .wakeRequest(wakeRequest));

// ===== tb/wwd_core_model.sv
// Processor core model: clear, sleep and start-up state, plus the slow oscillator.
// Assumes the bench raises the commands just after a rising edge.
`timescale 1ns/100ps
module wwd_core_model
  import wwd_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          clearCmd,
  input  wire logic          sleepCmd,
  input  wire logic          ostCmd,
  output wwd_pkg::wwd_core_s core,
  output logic               wdogOscPin
);
  logic [2:0] oscDiv;

  initial begin
    oscDiv     = 3'h0;
    wdogOscPin = 1'b0;
    core       = '0;
  end

  // Free-running oscillator, one tick every 16 core cycles
  always @(posedge core_clk) begin
    oscDiv <= oscDiv + 3'h1;
    if (oscDiv == 3'h7) begin
      wdogOscPin <= ~wdogOscPin;
    end
  end

  // A sleeping core executes no clear instruction
  always @(posedge core_clk) begin
    core.clearInstr <= clearCmd & ~sleepCmd;
    core.sleeping   <= sleepCmd;
    core.ostRunning <= ostCmd;
  end
endmodule

// ===== tb/wwd_windowed_watchdog_tb.sv
// Self-checking bench for the windowed watchdog.
// Assumes the checker binds itself and the core model drives core and oscillator.
`timescale 1ns/100ps
module wwd_windowed_watchdog_tb;
  import wwd_pkg::*;
  localparam int T = 16;
  logic         core_clk;
  logic         resetn;
  wwd_apb_req_s req;
  wwd_apb_rsp_s rsp;
  wwd_cfg_s     cfg;
  wwd_core_s    core;
  logic         osc;
  logic         rstReq;
  logic         wakeReq;
  logic         clearCmd;
  logic         sleepCmd;
  logic         ostCmd;
  logic         lastErr;
  logic [31:0]  rd;
  int           bad_count;
  int           n_tests;

  wwd_windowed_watchdog i_dut (.core_clk(core_clk), .resetn(resetn), .apbReq(req),
    .apbRsp(rsp), .cfg(cfg), .core(core), .wdogOscPin(osc), .resetRequest(rstReq),
    .wakeRequest(wakeReq));
  wwd_core_model i_core (.core_clk(core_clk), .clearCmd(clearCmd), .sleepCmd(sleepCmd),
    .ostCmd(ostCmd), .core(core), .wdogOscPin(osc));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    lastErr = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      chk(0, 1, "bus timeout");
      final_report();
    end
    // One idle edge so the next setup never lands on the release
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e}, "register read");
  endtask

  task automatic waitReq(input bit wake, input int lim, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (n < lim && (wake ? wakeReq : rstReq) !== 1'b1);
  endtask

  task automatic expTo(input bit wake, input int nt);
    int n;
    waitReq(wake, nt * T + 4 * T, n);
    chk(n >= (nt - 1) * T - 8 && n <= nt * T + 8, 1, "time-out moment");
  endtask

  task automatic expNone(input bit wake, input int nt);
    int n;
    waitReq(wake, nt * T, n);
    chk(n, nt * T, "unexpected request");
  endtask

  task automatic causeChk(input logic [7:0] e);
    rdc(ADDR_CAUSE, e);
    wr(ADDR_CAUSE, 8'h30);
  endtask

  task automatic clr();
    clearCmd <= 1'b1;
    @(posedge core_clk);
    clearCmd <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdc(ADDR_CTRL0, 8'h16);
    rdc(ADDR_CTRL1, 8'h07);
    rdc(ADDR_CAUSE, 8'h30);
    wr(ADDR_STATUS, 8'h00);
    rdc(ADDR_STATUS, 8'h18);
    apb(1'b0, 8'h1c, 32'h0);
    chk(lastErr, 1, "unmapped error");
    $display("test regs done");
  endtask

  task automatic t_period();
    wr(ADDR_CTRL0, 8'h00);
    expTo(0, 32);
    rdc(ADDR_STATUS, 8'h08);
    causeChk(8'h20);
    wr(ADDR_CTRL0, 8'h26);
    expTo(0, 32);
    wr(ADDR_CTRL0, 8'h02);
    expTo(0, 64);
    repeat (20 * T) @(posedge core_clk);
    wr(ADDR_CTRL1, 8'h07);
    expTo(0, 64);
    cfg.periodSel <= 5'h00;
    wr(ADDR_CTRL0, 8'h02);
    expTo(0, 32);
    rdc(ADDR_CTRL0, 8'h00);
    cfg.periodSel <= PERIOD_SW_SEL;
    wr(ADDR_CTRL0, 8'h00);
    $display("test period done");
  endtask

  task automatic t_modes();
    logic [1:0] md [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 5; i++) begin
      cfg.mode <= md[i];
      wr(ADDR_CTRL0, {7'h0, i != 1});
      if (i > 1)
        expTo(0, 32);
      else
        expNone(0, 40);
    end
    $display("test modes done");
  endtask

  task automatic t_window();
    int n;
    cfg.windowSel <= 3'h0;
    wr(ADDR_CTRL0, 8'h00);
    rdc(ADDR_CTRL1, 8'h00);
    apb(1'b0, ADDR_CTRL0, 32'h0);
    apb(1'b0, ADDR_WIN_CNT, 32'h0);
    chk(rd[TMR_STATE_BIT], 1, "armed state");
    clr();
    waitReq(0, 8, n);
    chk(n < 8, 1, "early clear");
    causeChk(8'h00);
    wr(ADDR_CTRL0, 8'h00);
    repeat (29 * T) @(posedge core_clk);
    clr();
    waitReq(0, 8, n);
    chk(n < 8, 1, "unarmed clear");
    causeChk(8'h10);
    wr(ADDR_CTRL0, 8'h00);
    repeat (27 * T) @(posedge core_clk);
    apb(1'b0, ADDR_CTRL0, 32'h0);
    repeat (2 * T) @(posedge core_clk);
    clr();
    expNone(0, 20);
    rdc(ADDR_STATUS, 8'h18);
    cfg.windowSel <= WINDOW_SW_SEL;
    $display("test window done");
  endtask

  task automatic t_sleep();
    cfg.mode <= MODE_AWAKE;
    sleepCmd <= 1'b1;
    expNone(1, 40);
    cfg.mode <= MODE_ALWAYS;
    expTo(1, 32);
    sleepCmd <= 1'b0;
    @(posedge core_clk);
    rdc(ADDR_STATUS, 8'h00);
    causeChk(8'h20);
    ostCmd <= 1'b1;
    expNone(0, 40);
    ostCmd <= 1'b0;
    expTo(0, 32);
    $display("test sleep done");
  endtask

  initial begin
    bad_count = 0;
    n_tests = 0;
    resetn = 1'b0;
    req = '0;
    cfg = '{mode: MODE_ALWAYS, periodSel: PERIOD_SW_SEL, windowSel: WINDOW_SW_SEL,
            clockSel: CLOCK_SW_SEL};
    clearCmd = 1'b0;
    sleepCmd = 1'b0;
    ostCmd = 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_period();
    t_modes();
    t_window();
    t_sleep();
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdc(ADDR_CAUSE, 8'h30);
    final_report();
  end
endmodule
